/* rtl/cpusb_pkg.sv */
// Shared constants, encodings and state codes of the system-control executor.
package cpusb_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] A_INSTR = 8'h00;
	localparam logic [7:0] A_EXT   = 8'h04;
	localparam logic [7:0] A_CTRL  = 8'h08;
	localparam logic [7:0] A_STAT  = 8'h0c;
	localparam logic [7:0] A_PC    = 8'h10;
	localparam logic [2:0] A_GR_HI = 3'h1;
	// ==========================================================
	// Instruction fields
	localparam int OP_LSB  = 12;
	localparam int OP2_LSB = 8;
	localparam int RA_LSB  = 4;
	localparam int RD_LSB  = 0;
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_TRAP  = 4'h1;
	localparam logic [3:0] OP_RTE   = 4'h2;
	localparam logic [3:0] OP_SLEEP = 4'h3;
	localparam logic [3:0] OP_LDC   = 4'h4;
	localparam logic [3:0] OP_STC   = 4'h5;
	localparam logic [3:0] OP_AND_CONTROL  = 4'h6;
	localparam logic [3:0] OP_ORC   = 4'h7;
	localparam logic [3:0] OP_XOR_CONTROL  = 4'h8;
	localparam logic [3:0] OP_BMOV  = 4'h9;
	localparam logic [3:0] OP_BIT   = 4'ha;
	localparam logic [3:0] OP_BCC   = 4'hb;
	localparam logic [1:0] MD_REG = 2'h0;
	localparam logic [1:0] MD_MEM = 2'h1;
	localparam logic [1:0] MD_IMM = 2'h2;
	localparam logic [1:0] BO_SET = 2'h0;
	localparam logic [1:0] BO_CLR = 2'h1;
	localparam logic [1:0] BO_INV = 2'h2;
	localparam logic [1:0] BO_CST = 2'h3;
	localparam logic [1:0] EXT_NONE = 2'h0;
	localparam logic [1:0] EXT_8    = 2'h1;
	localparam logic [1:0] EXT_16   = 2'h2;
	localparam logic [1:0] EXT_32   = 2'h3;
	// ==========================================================
	// Flags, reset values, steps
	localparam int CC_C = 0;
	localparam int CC_V = 1;
	localparam int CC_Z = 2;
	localparam int CC_N = 3;
	localparam int CC_I = 7;
	localparam logic [7:0]  CCR_RST    = 8'h80;
	localparam logic [7:0]  EXR_RST    = 8'h07;
	localparam logic [31:0] PC_RST     = 32'h0000_0000;
	localparam logic [31:0] UNIT_BYTES = 32'h0000_0002;
	localparam logic [31:0] INC_BYTE   = 32'h0000_0001;
	localparam logic [31:0] VEC_BASE   = 32'h0000_0020;
	localparam logic [2:0]  GR_CNT = 3'h4;
	localparam logic [2:0]  GR_SRC = 3'h5;
	localparam logic [2:0]  GR_DST = 3'h6;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_EXEC  = 3'b001,
		S_MRD   = 3'b010,
		S_MWR   = 3'b011,
		S_BRD   = 3'b100,
		S_MVRD  = 3'b101,
		S_MVWR  = 3'b110,
		S_SLEEP = 3'b111
	} cpusb_state_e;
endpackage

/* rtl/cpusb_bit_mod.sv */
// Byte modifier for the read-modify-write bit operations.
`timescale 1ns/1ps
module cpusb_bit_mod
	import cpusb_pkg::*;
(
	input  wire logic [7:0] byte_in,
	input  wire logic [2:0] bit_in,
	input  wire logic [1:0] kind_in,
	input  wire logic       inv_in,
	input  wire logic       carry_in,
	output logic      [7:0] byte_out
);
	// ==========================================================
	// Modify one bit, keep the other seven as read
	always_comb begin
		byte_out = byte_in;
		unique case (kind_in)
			BO_SET: byte_out[bit_in] = 1'b1;
			BO_CLR: byte_out[bit_in] = 1'b0;
			BO_INV: byte_out[bit_in] = ~byte_in[bit_in];
			BO_CST: byte_out[bit_in] = carry_in ^ inv_in;
		endcase
	end
endmodule

/* rtl/cpusb_exec.sv */
// System-control, block-move and bit-modify executor with an APB slave.
//
// Behaviour
// RULE_01 - Trap instruction saves state and jumps to its vector.
// RULE_02 - Return from exception restores saved PC and flags.
// RULE_03 - Sleep instruction enters power-down until woken.
// RULE_04 - Load control takes register, immediate or upper byte of memory word.
// RULE_05 - Store control writes register, or memory word with value in upper byte.
// RULE_06 - And control ANDs the control register with an 8-bit immediate.
// RULE_07 - Or control ORs the control register with an 8-bit immediate.
// RULE_08 - Xor control XORs the control register with an 8-bit immediate.
// RULE_09 - No operation only advances the program counter by two; code adds 4 or 6 when len_q sets an extension.
// RULE_10 - Block move copies bytes, bumps pointers, counts down, zero moves nothing.
// RULE_11 - Next instruction starts only after the block move finishes.
// RULE_12 - Instructions are sequences of two-byte units.
// RULE_13 - Operation field sits in the first four bits; second field allowed.
// RULE_14 - Three-bit address register field, four-bit data register field.
// RULE_15 - Extension of 8, 16 or 32 bits gives immediate or displacement.
// RULE_16 - Branch condition comes from a dedicated condition field.
// RULE_17 - Bit operations read a byte, modify one bit, write it back.
// RULE_18 - Software takes care with bit operations on write-only bits.
// RULE_19 - Bit clear can clear an I/O flag without a prior read.
// RULE_20 - Test-and-set operand register limited to registers 0, 1, 4, 5.
// RULE_21 - Store and load multiple use only registers 0 to 6.
// RULE_22 - Post-increment adds 1, 2 or 4 by access size.
`timescale 1ns/1ps
module cpusb_exec
	import cpusb_pkg::*;
(
	input  wire logic        ref_clk_in,
	input  wire logic        reset_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output logic             mem_req_out,
	output logic             mem_we_out,
	output logic             mem_word_out,
	output logic      [31:0] mem_addr_out,
	output logic      [15:0] mem_wdata_out,
	input  wire logic [15:0] mem_rdata_in,
	input  wire logic        mem_ack_in,
	input  wire logic        wake_in,
	output logic             power_down_out,
	output logic             exc_start_out,
	output logic             exc_return_out,
	output logic      [1:0]  exc_vector_out
);
	import cpusb_pkg::*;

	cpusb_state_e st_q;
	logic [31:0] gr_q [8];
	logic [31:0] pc_q, spc_q, ext_q, ea, disp, pc_step, rd_mux;
	logic [15:0] ins_q, cnt, wdata_q;
	logic [7:0]  ccr_q, exr_q, sccr_q, ctl, ctl_d, gbyte, bmod;
	logic [1:0]  len_q, vec_q;
	logic [3:0]  op, op2, rd;
	logic [2:0]  ra;
	logic        busy, go, apb_wr, perr_q, ctl_we, cond_ok, in_exc_q;
	logic        req_q, we_q, word_q, xs_q, xr_q, cnt_last, ack;
	logic [31:0] addr_q, prdata_q;

	// ==========================================================
	// Decode
	// RULE_13 operation fields
	assign op  = ins_q[OP_LSB +: 4];
	assign op2 = ins_q[OP2_LSB +: 4];
	// RULE_14 register fields
	assign ra  = ins_q[RA_LSB +: 3];
	assign rd  = ins_q[RD_LSB +: 4];
	assign busy = (st_q != S_IDLE);
	assign ack  = req_q && mem_ack_in;
	assign ctl  = op2[3] ? exr_q : ccr_q;
	// Bit 3 of the data field picks the low byte, otherwise bits 15:8.
	assign gbyte = rd[3] ? gr_q[rd[2:0]][7:0] : gr_q[rd[2:0]][15:8];
	assign cnt = op2[0] ? gr_q[GR_CNT][15:0] : {8'h00, gr_q[GR_CNT][7:0]};
	assign cnt_last = (cnt == 16'h0001);

	// RULE_15 extension sized and sign-extended
	always_comb begin
		unique case (len_q)
			EXT_NONE: disp = 32'h0;
			EXT_8:    disp = {{24{ext_q[7]}}, ext_q[7:0]};
			EXT_16:   disp = {{16{ext_q[15]}}, ext_q[15:0]};
			EXT_32:   disp = ext_q;
		endcase
	end
	assign ea = gr_q[ra] + disp;

	// RULE_12 two-byte units
	always_comb begin
		unique case (len_q)
			EXT_NONE: pc_step = UNIT_BYTES;
			EXT_32:   pc_step = UNIT_BYTES + UNIT_BYTES + UNIT_BYTES;
			default:  pc_step = UNIT_BYTES + UNIT_BYTES;
		endcase
	end

	// RULE_16 condition field
	always_comb begin
		unique case (op2)
			4'h0: cond_ok = 1'b1;
			4'h1: cond_ok = 1'b0;
			4'h2: cond_ok = !(ccr_q[CC_C] | ccr_q[CC_Z]);
			4'h3: cond_ok = ccr_q[CC_C] | ccr_q[CC_Z];
			4'h4: cond_ok = !ccr_q[CC_C];
			4'h5: cond_ok = ccr_q[CC_C];
			4'h6: cond_ok = !ccr_q[CC_Z];
			4'h7: cond_ok = ccr_q[CC_Z];
			4'h8: cond_ok = !ccr_q[CC_V];
			4'h9: cond_ok = ccr_q[CC_V];
			4'ha: cond_ok = !ccr_q[CC_N];
			4'hb: cond_ok = ccr_q[CC_N];
			4'hc: cond_ok = !(ccr_q[CC_N] ^ ccr_q[CC_V]);
			4'hd: cond_ok = ccr_q[CC_N] ^ ccr_q[CC_V];
			4'he: cond_ok = !(ccr_q[CC_Z] | (ccr_q[CC_N] ^ ccr_q[CC_V]));
			4'hf: cond_ok = ccr_q[CC_Z] | (ccr_q[CC_N] ^ ccr_q[CC_V]);
		endcase
	end

	// RULE_17 modify one bit of the byte read
	// RULE_19 bit clear writes zero without a prior flag test
	cpusb_bit_mod u_bit (
		.byte_in  (mem_rdata_in[7:0]),
		.bit_in   (ins_q[RD_LSB +: 3]),
		.kind_in  (op2[1:0]),
		.inv_in   (op2[2]),
		.carry_in (ccr_q[CC_C]),
		.byte_out (bmod)
	);

	// ==========================================================
	// APB slave
	// Read data and error are sampled in the setup cycle so that the
	// zero-wait access phase presents them from flip-flops.
	assign pready_out  = 1'b1;
	assign prdata_out  = prdata_q;
	assign pslverr_out = perr_q;
	assign apb_wr = psel_in && penable_in && pwrite_in && !perr_q;
	assign go = apb_wr && (paddr_in == A_CTRL) && pwdata_in[0];

	always_comb begin
		rd_mux = 32'h0;
		if (paddr_in[7:5] == A_GR_HI)
			rd_mux = gr_q[paddr_in[4:2]];
		else if (paddr_in == A_INSTR)
			rd_mux = {16'h0, ins_q};
		else if (paddr_in == A_EXT)
			rd_mux = ext_q;
		else if (paddr_in == A_CTRL)
			rd_mux = {29'h0, len_q, busy};
		else if (paddr_in == A_STAT)
			rd_mux = {14'h0, in_exc_q, st_q == S_SLEEP, exr_q, ccr_q};
		else if (paddr_in == A_PC)
			rd_mux = pc_q;
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			prdata_q <= 32'h0;
			perr_q   <= 1'b0;
		end else if (psel_in && !penable_in) begin
			prdata_q <= rd_mux;
			perr_q   <= !((paddr_in[7:5] == A_GR_HI && paddr_in[1:0] == 2'h0)
				|| paddr_in == A_INSTR || paddr_in == A_EXT
				|| paddr_in == A_CTRL || paddr_in == A_STAT || paddr_in == A_PC)
				|| (pwrite_in && (busy || paddr_in == A_STAT));
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ins_q <= 16'h0;
			ext_q <= 32'h0;
			len_q <= EXT_NONE;
		end else if (apb_wr) begin
			if (paddr_in == A_INSTR)
				ins_q <= pwdata_in[15:0];
			if (paddr_in == A_EXT)
				ext_q <= pwdata_in;
			if (paddr_in == A_CTRL)
				len_q <= pwdata_in[2:1];
		end
	end

	// ==========================================================
	// Sequencer
	// RULE_11 the block stays busy, so no new go, until the move ends
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE: if (go) st_q <= S_EXEC;
				S_EXEC: begin
					st_q <= S_IDLE;
					// RULE_03 power-down
					if (op == OP_SLEEP)
						st_q <= S_SLEEP;
					if ((op == OP_LDC) && (op2[1:0] == MD_MEM))
						st_q <= S_MRD;
					if ((op == OP_STC) && (op2[1:0] == MD_MEM))
						st_q <= S_MWR;
					if (op == OP_BIT)
						st_q <= S_BRD;
					// RULE_10 zero count moves nothing
					if ((op == OP_BMOV) && (cnt != 16'h0))
						st_q <= S_MVRD;
				end
				S_MRD:   if (ack) st_q <= S_IDLE;
				S_MWR:   if (ack) st_q <= S_IDLE;
				S_BRD:   if (ack) st_q <= S_MWR;
				S_MVRD:  if (ack) st_q <= S_MVWR;
				S_MVWR:  if (ack) st_q <= cnt_last ? S_IDLE : S_MVRD;
				S_SLEEP: if (wake_in) st_q <= S_IDLE;
			endcase
		end
	end
	assign power_down_out = (st_q == S_SLEEP);

	// ==========================================================
	// Memory request port
	// A request stands until acknowledged; a held request after an
	// acknowledge is a new transfer.
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			req_q   <= 1'b0;
			we_q    <= 1'b0;
			word_q  <= 1'b0;
			addr_q  <= 32'h0;
			wdata_q <= 16'h0;
		end else if (st_q == S_EXEC) begin
			req_q  <= 1'b0;
			word_q <= 1'b0;
			we_q   <= 1'b0;
			// RULE_04 word read for memory source
			if ((op == OP_LDC) && (op2[1:0] == MD_MEM)) begin
				req_q  <= 1'b1;
				word_q <= 1'b1;
				addr_q <= ea;
			end
			// RULE_05 word write, value in upper byte
			if ((op == OP_STC) && (op2[1:0] == MD_MEM)) begin
				req_q   <= 1'b1;
				word_q  <= 1'b1;
				we_q    <= 1'b1;
				addr_q  <= ea;
				wdata_q <= {ctl, 8'h00};
			end
			if (op == OP_BIT) begin
				req_q  <= 1'b1;
				addr_q <= gr_q[ra];
			end
			if ((op == OP_BMOV) && (cnt != 16'h0)) begin
				req_q  <= 1'b1;
				addr_q <= gr_q[GR_SRC];
			end
		end else if (ack) begin
			unique case (st_q)
				// RULE_17 write the modified byte back to the same address
				S_BRD: begin
					we_q    <= 1'b1;
					wdata_q <= {8'h00, bmod};
				end
				S_MVRD: begin
					we_q    <= 1'b1;
					addr_q  <= gr_q[GR_DST];
					wdata_q <= {8'h00, mem_rdata_in[7:0]};
				end
				S_MVWR: begin
					req_q  <= !cnt_last;
					we_q   <= 1'b0;
					addr_q <= gr_q[GR_SRC];
				end
				default: req_q <= 1'b0;
			endcase
		end
	end
	assign mem_req_out   = req_q;
	assign mem_we_out    = we_q;
	assign mem_word_out  = word_q;
	assign mem_addr_out  = addr_q;
	assign mem_wdata_out = wdata_q;

	// ==========================================================
	// Control registers
	always_comb begin
		ctl_we = 1'b0;
		ctl_d  = ctl;
		if (st_q == S_EXEC) begin
			unique case (op)
				OP_LDC: begin
					ctl_we = (op2[1:0] != MD_MEM);
					ctl_d  = (op2[1:0] == MD_IMM) ? ext_q[7:0] : gbyte;
				end
				// RULE_06 and with immediate
				OP_AND_CONTROL: begin
					ctl_we = 1'b1;
					ctl_d  = ctl & ext_q[7:0];
				end
				// RULE_07 or with immediate
				OP_ORC: begin
					ctl_we = 1'b1;
					ctl_d  = ctl | ext_q[7:0];
				end
				// RULE_08 xor with immediate
				OP_XOR_CONTROL: begin
					ctl_we = 1'b1;
					ctl_d  = ctl ^ ext_q[7:0];
				end
				default: ctl_we = 1'b0;
			endcase
		end else if ((st_q == S_MRD) && ack) begin
			// RULE_04 only the upper byte of the word is kept
			ctl_we = 1'b1;
			ctl_d  = mem_rdata_in[15:8];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			ccr_q <= CCR_RST;
			exr_q <= EXR_RST;
		end else if ((st_q == S_EXEC) && (op == OP_TRAP)) begin
			ccr_q[CC_I] <= 1'b1;
		end else if ((st_q == S_EXEC) && (op == OP_RTE)) begin
			ccr_q <= sccr_q;
		end else if (ctl_we) begin
			if (op2[3])
				exr_q <= ctl_d;
			else
				ccr_q <= ctl_d;
		end
	end

	// ==========================================================
	// Program counter and exception state
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pc_q     <= PC_RST;
			spc_q    <= PC_RST;
			sccr_q   <= CCR_RST;
			in_exc_q <= 1'b0;
			xs_q     <= 1'b0;
			xr_q     <= 1'b0;
			vec_q    <= 2'h0;
		end else begin
			xs_q <= 1'b0;
			xr_q <= 1'b0;
			if ((st_q == S_IDLE) && apb_wr && (paddr_in == A_PC))
				pc_q <= pwdata_in;
			if (st_q == S_EXEC) begin
				// RULE_09 plain advance for no operation and the rest
				pc_q <= pc_q + pc_step;
				// RULE_01 trap entry
				if (op == OP_TRAP) begin
					spc_q    <= pc_q + pc_step;
					sccr_q   <= ccr_q;
					pc_q     <= VEC_BASE + {28'h0, ins_q[1:0], 2'h0};
					vec_q    <= ins_q[1:0];
					in_exc_q <= 1'b1;
					xs_q     <= 1'b1;
				end
				// RULE_02 resume interrupted flow
				if (op == OP_RTE) begin
					pc_q     <= spc_q;
					in_exc_q <= 1'b0;
					xr_q     <= 1'b1;
				end
				if ((op == OP_BCC) && cond_ok)
					pc_q <= pc_q + pc_step + {{24{ins_q[7]}}, ins_q[7:0]};
			end
		end
	end
	assign exc_start_out  = xs_q;
	assign exc_return_out = xr_q;
	assign exc_vector_out = vec_q;

	// ==========================================================
	// General registers
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			for (int i = 0; i < 8; i++)
				gr_q[i] <= 32'h0;
		end else begin
			if (apb_wr && (paddr_in[7:5] == A_GR_HI))
				gr_q[paddr_in[4:2]] <= pwdata_in;
			if ((st_q == S_EXEC) && (op == OP_STC) && (op2[1:0] == MD_REG)) begin
				if (rd[3])
					gr_q[rd[2:0]][7:0] <= ctl;
				else
					gr_q[rd[2:0]][15:8] <= ctl;
			end
			// RULE_22 byte post-increment by one
			if ((st_q == S_MVRD) && ack)
				gr_q[GR_SRC] <= gr_q[GR_SRC] + INC_BYTE;
			// RULE_10 count down and advance the destination
			if ((st_q == S_MVWR) && ack) begin
				gr_q[GR_DST] <= gr_q[GR_DST] + INC_BYTE;
				if (op2[0])
					gr_q[GR_CNT][15:0] <= gr_q[GR_CNT][15:0] - 16'h0001;
				else
					gr_q[GR_CNT][7:0] <= gr_q[GR_CNT][7:0] - 8'h01;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);

	a_trap_entry: assert property ((st_q == S_EXEC) && (op == OP_TRAP) |=> // RULE_01
		exc_start_out && in_exc_q && (pc_q == VEC_BASE + {28'h0, vec_q, 2'h0}))
		else $error("trap did not enter its vector");
	a_rte_resume: assert property ((st_q == S_EXEC) && (op == OP_RTE) |=> // RULE_02
		exc_return_out && !in_exc_q && (pc_q == $past(spc_q)))
		else $error("return did not restore the program counter");
	a_sleep_hold: assert property ((st_q == S_EXEC) && (op == OP_SLEEP) && !wake_in |=> // RULE_03
		power_down_out)
		else $error("sleep did not enter power-down");
	a_ldc_upper: assert property ((st_q == S_MRD) && ack && !op2[3] |=> // RULE_04
		ccr_q == $past(mem_rdata_in[15:8]))
		else $error("load control took the wrong byte");
	a_stc_word: assert property ((st_q == S_MWR) && (op == OP_STC) |-> // RULE_05
		mem_word_out && mem_we_out && (mem_wdata_out == {ctl, 8'h00}))
		else $error("store control word malformed");
	a_and_control_value: assert property ((st_q == S_EXEC) && (op == OP_AND_CONTROL) && !op2[3] |=> // RULE_06
		ccr_q == ($past(ccr_q) & $past(ext_q[7:0])))
		else $error("and control result wrong");
	a_orc_value: assert property ((st_q == S_EXEC) && (op == OP_ORC) && op2[3] |=> // RULE_07
		exr_q == ($past(exr_q) | $past(ext_q[7:0])))
		else $error("or control result wrong");
	a_xor_control_value: assert property ((st_q == S_EXEC) && (op == OP_XOR_CONTROL) && !op2[3] |=> // RULE_08
		ccr_q == ($past(ccr_q) ^ $past(ext_q[7:0])))
		else $error("xor control result wrong");
	a_nop_step: assert property ((st_q == S_EXEC) && (op == OP_NOP) && (len_q == EXT_NONE) |=> // RULE_09
		(pc_q == $past(pc_q) + 32'h2) && $stable(ccr_q) && (st_q == S_IDLE))
		else $error("no operation changed more than the counter");
	a_move_zero: assert property ((st_q == S_EXEC) && (op == OP_BMOV) && (cnt == 16'h0) |=> // RULE_10
		(st_q == S_IDLE) && !mem_req_out)
		else $error("zero count started a move");
	a_move_ends: assert property ((st_q == S_MVWR) && ack && !cnt_last |=> // RULE_11
		((st_q == S_MVRD) && busy) [*2])
		else $error("move ended before the count ran out");
	a_src_step: assert property ((st_q == S_MVRD) && ack |=> // RULE_22
		gr_q[GR_SRC] == $past(gr_q[GR_SRC]) + 32'h1)
		else $error("source pointer did not advance by one");
	a_bit_rmw: assert property ((st_q == S_BRD) && ack |=> // RULE_17
		(st_q == S_MWR) && mem_we_out && (mem_addr_out == $past(mem_addr_out)))
		else $error("bit operation did not write back");

	c_trap_rte: cover property ((st_q == S_EXEC) && (op == OP_TRAP) ##[1:50]
		(st_q == S_EXEC) && (op == OP_RTE));
	c_move_multi: cover property ((st_q == S_MVWR) && ack && !cnt_last);
	c_bit_clear: cover property ((st_q == S_MWR) && (op == OP_BIT) && (op2[1:0] == BO_CLR));
	c_ldc_memory: cover property ((st_q == S_MRD) && ack);
endmodule

/* verification/cpusb_mem_model.sv */
// Behavioural data memory on the executor's memory port.
`timescale 1ns/1ps
module cpusb_mem_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic        word_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic [3:0]  delay_in,
	output logic      [15:0] rdata_out = 16'h0,
	output logic             ack_out = 1'b0
);
	logic [7:0]  mem [256];
	logic [7:0]  a;
	logic [3:0]  wait_q;
	logic [15:0] last_q;
	logic [15:0] rd_w;
	assign a = addr_in[7:0];
	assign rd_w = word_in ? {mem[a], mem[a + 8'h1]} : {~mem[a], mem[a]};
	// ==========================================================
	// Transfer engine
	// Outside ack the data bus shows the inverse of the last read, so stale data never matches.
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~last_q;
		if (rst_in) begin
			wait_q <= 4'h0;
			last_q <= 16'h0;
		end else if (req_in && !ack_out) begin
			if (wait_q < delay_in) begin
				wait_q <= wait_q + 4'h1;
			end else begin
				wait_q <= 4'h0;
				ack_out <= 1'b1;
				if (we_in) begin
					mem[a] <= word_in ? wdata_in[15:8] : wdata_in[7:0];
					if (word_in) begin
						mem[a + 8'h1] <= wdata_in[7:0];
					end
				end else begin
					rdata_out <= rd_w;
					last_q <= rd_w;
				end
			end
		end
	end
endmodule

/* verification/cpu_system_and_block_move_exec_tb.sv */
// Self-checking bench for the system-control and block-move executor.
`timescale 1ns/1ps
module cpu_system_and_block_move_exec_tb;
	import cpusb_pkg::*;
	typedef struct packed {
		logic [15:0] ins;
		logic [31:0] ext;
		logic [1:0]  len;
		logic [15:0] st;
		logic [3:0]  stp;
		logic [7:0]  gr2;
	} cpusb_row_s;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, wake = 0, e;
	logic [7:0]  paddr = 0;
	logic [31:0] pwd = 0, prd, r, maddr;
	logic        prdy, perr, req, we, word, ack, pd, xs, xr;
	logic [15:0] mwd, mrd;
	logic [1:0]  vec;
	logic [3:0]  dly = 0;
	int          n_mismatch = 0, samples_checked = 0, n_xs = 0, n_xr = 0;
	cpusb_row_s  rows [11];
	logic [23:0] bops [5] = '{24'ha0705b, 24'ha17159, 24'ha277d9, 24'ha373d1, 24'ha772d5};
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		n_xs += (xs === 1'b1);
		n_xr += (xr === 1'b1);
	end
	cpusb_exec i_dut (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(prdy), .pslverr_out(perr), .mem_req_out(req), .mem_we_out(we),
		.mem_word_out(word), .mem_addr_out(maddr), .mem_wdata_out(mwd),
		.mem_rdata_in(mrd), .mem_ack_in(ack), .wake_in(wake), .power_down_out(pd),
		.exc_start_out(xs), .exc_return_out(xr), .exc_vector_out(vec));
	cpusb_mem_model i_mem (.clk_in(clk), .rst_in(rst), .req_in(req), .we_in(we),
		.word_in(word), .addr_in(maddr), .wdata_in(mwd), .delay_in(dly),
		.rdata_out(mrd), .ack_out(ack));
	// ==========================================================
	// Reporting
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tmo();
		n_mismatch++;
		$display("CHECK FAILED wait limit expected done seen stuck");
		conclude();
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask
	// ==========================================================
	// Bus cycles
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 20);
		if (k >= 20)
			tmo();
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, x, r);
	endtask
	task automatic go(input logic [15:0] i, input logic [31:0] x, input logic [1:0] l);
		apb(1'b1, A_EXT, x);
		apb(1'b1, A_INSTR, {16'h0, i});
		apb(1'b1, A_CTRL, {29'h0, l, 1'b1});
	endtask
	task automatic idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, A_CTRL, 32'h0);
			k++;
		end while (r[0] !== 1'b0 && k < 500);
		if (k >= 500)
			tmo();
	endtask
	task automatic run(input logic [15:0] i, input logic [31:0] x, input logic [1:0] l);
		go(i, x, l);
		idle();
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		tmo();
	end
	// ==========================================================
	// Main sequence
	initial begin
		rows = '{'{16'h0000, 32'h00, 2'h0, 16'h0780, 4'h2, 8'h00},
			'{16'h4200, 32'ha5, 2'h1, 16'h07a5, 4'h4, 8'h00},
			'{16'h6000, 32'h0f, 2'h1, 16'h0705, 4'h4, 8'h00},
			'{16'h7800, 32'h30, 2'h1, 16'h3705, 4'h4, 8'h00},
			'{16'h8800, 32'hff, 2'h2, 16'hc805, 4'h4, 8'h00},
			'{16'h8000, 32'hff, 2'h3, 16'hc8fa, 4'h6, 8'h00},
			'{16'h4009, 32'h00, 2'h0, 16'hc834, 4'h2, 8'h00},
			'{16'h580a, 32'h00, 2'h0, 16'hc834, 4'h2, 8'hc8},
			'{16'h4801, 32'h00, 2'h0, 16'h1234, 4'h2, 8'hc8},
			'{16'hb70a, 32'h00, 2'h0, 16'h1234, 4'hc, 8'hc8},
			'{16'hb60a, 32'h00, 2'h0, 16'h1234, 4'h2, 8'hc8}};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rchk("reset status", A_STAT, 32'h0780);
		rchk("reset pc", A_PC, 32'h0);
		apb(1'b1, 8'h24, 32'h1234);
		foreach (rows[n]) begin
			apb(1'b1, A_PC, 32'h100);
			run(rows[n].ins, rows[n].ext, rows[n].len);
			rchk("status", A_STAT, {16'h0, rows[n].st});
			rchk("pc", A_PC, 32'h100 + {28'h0, rows[n].stp});
			rchk("gr2", 8'h28, {24'h0, rows[n].gr2});
		end
		$display("test control ops done");
		i_mem.mem[8'h40] = 8'h9c;
		i_mem.mem[8'h41] = 8'h11;
		apb(1'b1, 8'h2c, 32'h40);
		run(16'h4130, 32'h0, 2'h0);
		rchk("load mem", A_STAT, 32'h129c);
		run(16'h5130, 32'h0, 2'h0);
		chk("store mem", 32'h9c00, {16'h0, i_mem.mem[8'h40], i_mem.mem[8'h41]});
		$display("test memory control done");
		for (int n = 0; n < 5; n++) begin
			i_mem.mem[8'h80 + n] = 8'h11 * (n + 1);
			i_mem.mem[8'ha0 + n] = 8'h00;
		end
		dly <= 4'h3;
		apb(1'b1, 8'h30, 32'h0103);
		apb(1'b1, 8'h34, 32'h80);
		apb(1'b1, 8'h38, 32'ha0);
		go(16'h9000, 32'h0, 2'h0);
		apb(1'b1, A_CTRL, 32'h1);
		chk("busy refusal", 32'h1, {31'h0, e});
		idle();
		for (int n = 0; n < 4; n++) begin
			chk("moved", (n < 3) ? 8'h11 * (n + 1) : 0, {24'h0, i_mem.mem[8'ha0 + n]});
		end
		rchk("count", 8'h30, 32'h0100);
		rchk("src", 8'h34, 32'h83);
		rchk("dst", 8'h38, 32'ha3);
		apb(1'b1, A_PC, 32'h100);
		run(16'h9000, 32'h0, 2'h0);
		rchk("zero pc", A_PC, 32'h102);
		rchk("zero src", 8'h34, 32'h83);
		apb(1'b1, 8'h30, 32'h2);
		run(16'h9100, 32'h0, 2'h0);
		rchk("word count", 8'h30, 32'h0);
		rchk("word dst", 8'h38, 32'ha5);
		chk("word byte", 32'h55, {24'h0, i_mem.mem[8'ha4]});
		$display("test block move done");
		// Bit ops hit plain RAM only; no test-and-set or multiples.
		dly <= 4'h1;
		apb(1'b1, 8'h3c, 32'h60);
		i_mem.mem[8'h60] = 8'h5a;
		foreach (bops[n]) begin
			run(bops[n][23:8], 32'h0, 2'h0);
			chk("bit op", {24'h0, bops[n][7:0]}, {24'h0, i_mem.mem[8'h60]});
		end
		$display("test bit ops done");
		run(16'h6000, 32'h7f, 2'h1);
		apb(1'b1, A_PC, 32'h100);
		run(16'h1002, 32'h0, 2'h0);
		rchk("trap pc", A_PC, 32'h28);
		rchk("trap status", A_STAT, 32'h0002_129c);
		chk("trap pulse", 32'h1, n_xs);
		chk("vector", 32'h2, {30'h0, vec});
		run(16'h2000, 32'h0, 2'h0);
		rchk("return pc", A_PC, 32'h102);
		rchk("return status", A_STAT, 32'h121c);
		chk("return pulse", 32'h1, n_xr);
		go(16'h3000, 32'h0, 2'h0);
		repeat (2) @(posedge clk);
		chk("asleep", 32'h1, {31'h0, pd});
		apb(1'b1, A_CTRL, 32'h1);
		chk("sleep refusal", 32'h1, {31'h0, e});
		rchk("sleep status", A_STAT, 32'h0001_121c);
		wake <= 1'b1;
		idle();
		wake <= 1'b0;
		chk("awake", 32'h0, {31'h0, pd});
		$display("test exceptions and sleep done");
		rchk("unmapped", 8'h14, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, e});
		apb(1'b1, A_STAT, 32'hffff);
		chk("ro err", 32'h1, {31'h0, e});
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rchk("rerun status", A_STAT, 32'h0780);
		rchk("rerun src", 8'h34, 32'h0);
		$display("test refusals and reset done");
		conclude();
	end
endmodule
